// ===== rtl/ptl_target.sv
// Target side of 32-bit PCI transactions: claim, handshake, burst addressing.
// Assumes bus inputs are synchronous to clock and that the BAR bases
// come from a configuration block outside, aligned to the window size.

// Function
// - Address phase lasts exactly one clock
// - Capture address and command, then decode
// - Target generates sequential burst addresses itself
// - Claim decoded hit by asserting DEVSEL
// - Transfer exactly the enabled bytes; reads fetch all four lanes instead
// - Move data only when IRDY and TRDY
// - After last transfer deassert TRDY and DEVSEL
// - Bus idle only when all four high
// - Up to six memory or I/O windows
// - Register offsets relative to BAR base
module ptl_target #(
  parameter int NUM_BARS = ptl_pkg::MAX_BARS,     // Windows in use
  parameter int WIN_BITS = 8,                     // Log2 of window size in bytes
  parameter logic [ptl_pkg::MAX_BARS-1:0] BAR_IS_IO = 6'h3f  // Window space type
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic frameN,               // Bus FRAME level
  input wire logic irdyN,                // Bus IRDY level
  input wire logic trdyNIn,              // Bus TRDY wire level
  input wire logic devselNIn,            // Bus DEVSEL wire level
  input wire logic [ptl_pkg::BE_W-1:0] cbeN,
  input wire logic [ptl_pkg::AD_W-1:0] adIn,
  input wire logic [NUM_BARS*ptl_pkg::AD_W-1:0] barBase,
  input wire logic [NUM_BARS-1:0] barEnable,
  output logic [ptl_pkg::AD_W-1:0] adOut,
  output logic adOe,
  output logic trdyN,
  output logic trdyOe,
  output logic devselN,
  output logic devselOe,
  output logic busIdle,
  output logic reqValid,
  input wire logic reqReady,
  output logic reqWrite,
  output logic [ptl_pkg::BAR_IDX_W-1:0] reqBar,
  output logic [WIN_BITS-1:0] reqOffset,
  output logic [ptl_pkg::AD_W-1:0] reqData,
  output logic [ptl_pkg::BE_W-1:0] reqByteEn,
  input wire logic rspValid,
  input wire logic [ptl_pkg::AD_W-1:0] rspData
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  localparam int EW = 1 + ptl_pkg::BAR_IDX_W + WIN_BITS + ptl_pkg::AD_W + ptl_pkg::BE_W;

  // Window count and size must fit the decode
  generate
    if (NUM_BARS < 1 || NUM_BARS > ptl_pkg::MAX_BARS) begin : gBadBars
      $error("NUM_BARS must be 1 to 6");
    end
    if (WIN_BITS < 2 || WIN_BITS > 30) begin : gBadWin
      $error("WIN_BITS must be 2 to 30");
    end
  endgenerate

  // ****************************************
  // Declarations
  // ****************************************
  ptl_pkg::ptl_state_e stateReg, stateNext;  // Sequencer
  logic [ptl_pkg::AD_W-1:0] addrReg, addrNext;    // Current data phase address
  logic [ptl_pkg::AD_W-1:0] adOutReg, adOutNext;  // Read data driven out
  logic writeReg, writeNext;                      // Transaction direction
  logic [ptl_pkg::BAR_IDX_W-1:0] barReg, barNext; // Window that was hit
  logic pendReg, pendNext;                        // Read request outstanding
  logic trdyNReg, trdyNext;
  logic devselNReg, devselNext;
  logic trdyOeReg, trdyOeNext;
  logic devselOeReg, devselOeNext;
  logic adOeReg, adOeNext;
  logic busIdleReg, busIdleNext;                  // Bus was idle last cycle
  logic [NUM_BARS-1:0] hitVec;                    // Per window match
  logic hit;
  logic [ptl_pkg::BAR_IDX_W-1:0] hitIdx;
  logic cmdRead, cmdWrite, cmdIo;
  logic start;                                    // Address phase on idle bus
  logic xfer;                                     // Data moves at this edge
  logic push, pop;
  logic [EW-1:0] pushEntry;
  logic [EW-1:0] ent0Reg, ent0Next, ent1Reg, ent1Next;
  logic [1:0] countReg, countNext;
  logic validReg, validNext;
  logic room;                                     // Space after this edge

  // ****************************************
  // Address and command decode
  // ****************************************
  // command decode
  always_comb begin
    cmdRead = (cbeN == ptl_pkg::CMD_IO_RD) || (cbeN == ptl_pkg::CMD_MEM_RD) ||
              (cbeN == ptl_pkg::CMD_MEM_RD_MUL) || (cbeN == ptl_pkg::CMD_MEM_RD_LINE);
    cmdWrite = (cbeN == ptl_pkg::CMD_IO_WR) || (cbeN == ptl_pkg::CMD_MEM_WR) ||
               (cbeN == ptl_pkg::CMD_MEM_WR_INV);
    cmdIo = (cbeN == ptl_pkg::CMD_IO_RD) || (cbeN == ptl_pkg::CMD_IO_WR);
  end

  // One comparator per window; upper bits against the assigned base
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BARS; gi++) begin : gWin
      assign hitVec[gi] = barEnable[gi] && (BAR_IS_IO[gi] == cmdIo) &&
        (adIn[ptl_pkg::AD_W-1:WIN_BITS] ==
         barBase[gi*ptl_pkg::AD_W+WIN_BITS +: ptl_pkg::AD_W-WIN_BITS]);
    end
  endgenerate

  // Lowest matching window wins; overlapping bases are a setup fault
  always_comb begin
    hit = 1'b0;
    hitIdx = '0;
    for (int i = NUM_BARS - 1; i >= 0; i--) begin
      if (hitVec[i]) begin
        hit = 1'b1;
        hitIdx = ptl_pkg::BAR_IDX_W'(i);
      end
    end
  end

  // address phase only after an idle cycle
  assign start = (stateReg == ptl_pkg::PTL_IDLE) && busIdleReg && !frameN;
  assign xfer = (stateReg == ptl_pkg::PTL_DATA) && !irdyN && !trdyNReg;
  assign pop = validReg && reqReady;

  // ****************************************
  // Target sequencer
  // ****************************************
  // Next values of the bus side state
  always_comb begin
    stateNext = stateReg;
    addrNext = addrReg;
    adOutNext = adOutReg;
    writeNext = writeReg;
    barNext = barReg;
    pendNext = pendReg;
    trdyNext = trdyNReg;
    devselNext = devselNReg;
    trdyOeNext = trdyOeReg;
    devselOeNext = devselOeReg;
    adOeNext = 1'b0;
    push = 1'b0;
    pushEntry = '0;
    // idle needs all four strobes high
    busIdleNext = frameN && irdyN && trdyNIn && devselNIn;
    case (stateReg)
      ptl_pkg::PTL_IDLE: begin
        if (start) begin
          addrNext = adIn;
          writeNext = cmdWrite;
          barNext = hitIdx;
          pendNext = 1'b0;
          if (hit && (cmdRead || cmdWrite)) begin
            stateNext = ptl_pkg::PTL_DATA;
            devselNext = 1'b0;
            devselOeNext = 1'b1;
            trdyOeNext = 1'b1;
            trdyNext = 1'b1;
          end else begin
            stateNext = ptl_pkg::PTL_SKIP;
          end
        end
      end
      ptl_pkg::PTL_DATA: begin
        // Read drive starts after the turnaround cycle
        adOeNext = !writeReg;
        if (writeReg) begin
          if (xfer) begin
            push = 1'b1;
            pushEntry = {1'b1, barReg, addrReg[WIN_BITS-1:0], adIn, ~cbeN};
          end
        end else if (!xfer && !pendReg && trdyNReg && validReg == 1'b0) begin
          // One read in flight keeps fetched data in order
          push = 1'b1;
          pendNext = 1'b1;
          pushEntry = {1'b0, barReg, addrReg[WIN_BITS-1:0], ptl_pkg::AD_RESET,
                       ptl_pkg::READ_BE};
        end
        if (xfer) begin
          addrNext = addrReg + ptl_pkg::ADDR_STEP;
        end
        if (writeReg) begin
          // TRDY only while the buffer can take the next word
          trdyNext = !room;
        end else if (xfer) begin
          trdyNext = 1'b1;
        end else if (pendReg && rspValid) begin
          adOutNext = rspData;
          trdyNext = 1'b0;
          pendNext = 1'b0;
        end
        if ((xfer && frameN) || (frameN && irdyN)) begin
          stateNext = ptl_pkg::PTL_TURN;
          trdyNext = 1'b1;
          devselNext = 1'b1;
          adOeNext = 1'b0;
        end
      end
      ptl_pkg::PTL_TURN: begin
        trdyOeNext = 1'b0;
        devselOeNext = 1'b0;
        // Straight to idle: the strobes are high now, so a new master may start next cycle
        stateNext = ptl_pkg::PTL_IDLE;
      end
      ptl_pkg::PTL_SKIP: begin
        if (frameN && irdyN) begin
          stateNext = ptl_pkg::PTL_IDLE;
        end
      end
      default: begin
        stateNext = ptl_pkg::PTL_IDLE;
      end
    endcase
  end

  // Registers of the bus side
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= ptl_pkg::PTL_IDLE;
      addrReg <= ptl_pkg::AD_RESET;
      adOutReg <= ptl_pkg::AD_RESET;
      writeReg <= 1'b0;
      barReg <= '0;
      pendReg <= 1'b0;
      trdyNReg <= 1'b1;
      devselNReg <= 1'b1;
      trdyOeReg <= 1'b0;
      devselOeReg <= 1'b0;
      adOeReg <= 1'b0;
      busIdleReg <= 1'b1;
    end else begin
      stateReg <= stateNext;
      addrReg <= addrNext;
      adOutReg <= adOutNext;
      writeReg <= writeNext;
      barReg <= barNext;
      pendReg <= pendNext;
      trdyNReg <= trdyNext;
      devselNReg <= devselNext;
      trdyOeReg <= trdyOeNext;
      devselOeReg <= devselOeNext;
      adOeReg <= adOeNext;
      busIdleReg <= busIdleNext;
    end
  end

  // ****************************************
  // Two-entry request buffer
  // ****************************************
  // Entry 0 is the head, so outputs come straight from its flops
  always_comb begin
    ent0Next = ent0Reg;
    ent1Next = ent1Reg;
    countNext = countReg;
    case ({push, pop})
      2'b10: begin
        if (countReg == 2'h0) begin
          ent0Next = pushEntry;
        end else begin
          ent1Next = pushEntry;
        end
        countNext = countReg + 2'h1;
      end
      2'b01: begin
        ent0Next = ent1Reg;
        countNext = countReg - 2'h1;
      end
      2'b11: begin
        if (countReg == 2'h1) begin
          ent0Next = pushEntry;
        end else begin
          ent0Next = ent1Reg;
          ent1Next = pushEntry;
        end
      end
      default: begin
        countNext = countReg;
      end
    endcase
    validNext = (countNext != 2'h0);
    // Stall the next phase when the receiver falls behind
    room = (countNext != ptl_pkg::COUNT_FULL);
  end

  // Buffer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ent0Reg <= '0;
      ent1Reg <= '0;
      countReg <= 2'h0;
      validReg <= 1'b0;
    end else begin
      ent0Reg <= ent0Next;
      ent1Reg <= ent1Next;
      countReg <= countNext;
      validReg <= validNext;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign adOut = adOutReg;
  assign adOe = adOeReg;
  assign trdyN = trdyNReg;
  assign trdyOe = trdyOeReg;
  assign devselN = devselNReg;
  assign devselOe = devselOeReg;
  assign busIdle = busIdleReg;
  assign reqValid = validReg;
  assign {reqWrite, reqBar, reqOffset, reqData, reqByteEn} = ent0Reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence lastXfer;
    xfer && frameN;
  endsequence

  sequence releaseSeq;
    (devselN && trdyN && devselOe) ##1 (!devselOe && !trdyOe && !adOe);
  endsequence

  chk_claim_on_hit: assert property (start && hit && (cmdRead || cmdWrite) |=> !devselN && devselOe)
    else $error("hit not claimed");
  chk_miss_undriven: assert property (start && !hit |=> (!devselOe && !trdyOe && !adOe) [*2])
    else $error("miss drove the bus");
  chk_addr_capture: assert property (start |=> addrReg == $past(adIn))
    else $error("address not captured");
  chk_burst_step: assert property (xfer && !frameN |=> addrReg == $past(addrReg) + ptl_pkg::ADDR_STEP)
    else $error("burst address not advanced");
  chk_wait_holds: assert property (stateReg == ptl_pkg::PTL_DATA && (irdyN || trdyN) && !frameN |=> addrReg == $past(addrReg))
    else $error("data moved without both ready");
  chk_write_bytes: assert property (xfer && writeReg && countReg == 2'h0 |=> reqValid && reqByteEn == ~$past(cbeN) && reqData == $past(adIn))
    else $error("write bytes not passed as enabled");
  chk_end_release: assert property (lastXfer |=> releaseSeq)
    else $error("strobes not released after last transfer");
  chk_idle_gate: assert property (stateReg == ptl_pkg::PTL_IDLE && !frameN &&
    !$past(frameN && irdyN && trdyNIn && devselNIn) |=> stateReg != ptl_pkg::PTL_DATA)
    else $error("claimed on a busy bus");
  chk_offset_rel: assert property (push && countReg == 2'h0 |=> reqOffset == $past(addrReg[WIN_BITS-1:0]) && reqBar < NUM_BARS)
    else $error("offset not relative to window");

endmodule

// ===== rtl/ptl_pkg.sv
// Shared constants for the PCI target transaction logic.
// Assumes a 32-bit PCI bus sampled on the rising edge of one clock.
package ptl_pkg;

  // ****************************************
  // Bus widths and limits
  // ****************************************
  localparam int AD_W = 32;      // Address/data width
  localparam int BE_W = 4;       // Command/byte-enable width
  localparam int MAX_BARS = 6;   // Most resource blocks a function may ask for
  localparam int BAR_IDX_W = 3;  // Width of a window index
  localparam int BUF_DEPTH = 2;  // Entries in the request buffer

  // ****************************************
  // Bus commands taken in the address phase
  // ****************************************
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_MEM_RD_MUL = 4'hc;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

  // ****************************************
  // Burst and reset values
  // ****************************************
  localparam logic [AD_W-1:0] ADDR_STEP = 32'h0000_0004;  // One dword per data phase
  localparam logic [BE_W-1:0] READ_BE = 4'hf;              // Reads fetch all lanes
  localparam logic [AD_W-1:0] AD_RESET = 32'h0000_0000;
  localparam logic [1:0] COUNT_FULL = 2'h2;

  // Target sequencer states
  typedef enum logic [1:0] {
    PTL_IDLE = 2'b00,  // Waiting for an address phase on an idle bus
    PTL_DATA = 2'b01,  // Claimed, running data phases
    PTL_TURN = 2'b10,  // Driving strobes high one cycle before release
    PTL_SKIP = 2'b11   // Not ours, waiting for the bus to go quiet
  } ptl_state_e;

endpackage

// ===== tb/ptl_initiator.sv
// Behavioural bus master that runs one transaction at a time on request.
// Assumes the bench resolves the shared TRDY, DEVSEL and AD wires.
module ptl_initiator (
  input wire logic clock,
  input wire logic trdyNIn,
  input wire logic devselNIn,
  input wire logic [31:0] adWire,
  output logic frameN,
  output logic irdyN,
  output logic [3:0] cbeN,
  output logic [31:0] adDrv,
  output logic adDrvOe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Read data seen on the wire, one entry per transfer
  logic [31:0] rdQ[$];

  // Strobes parked high until a transaction starts
  initial begin
    frameN = 1'b1;
    irdyN = 1'b1;
    cbeN = 4'hf;
    adDrv = 32'h0;
    adDrvOe = 1'b0;
  end

  // ****************************************
  // One transaction of n dwords
  // ****************************************
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr, input int n,
                      output logic claimed);
    int i;
    int w;
    logic rd;
    rd = !cmd[0];
    claimed = 1'b1;
    // start on an idle bus, or anyway after 16 clocks of waiting
    w = 0;
    do begin
      @(posedge clock);
      w++;
    end while (!(frameN && irdyN && trdyNIn && devselNIn) && w < 16);
    // address and command with FRAME for one clock
    #1;
    frameN = 1'b0;
    adDrvOe = 1'b1;
    adDrv = addr;
    cbeN = cmd;
    @(posedge clock);
    for (i = 0; i < n && claimed; i++) begin
      #1;
      // final phase: IRDY low with FRAME high
      irdyN = 1'b0;
      frameN = (i == n - 1);
      // byte enables per phase, AD released on reads for turnaround
      cbeN = rd ? 4'h0 : 4'(i);
      adDrvOe = !rd;
      adDrv = 32'ha500_0000 + i;
      // hold the phase until TRDY; give up if nobody claims
      w = 0;
      do begin
        @(posedge clock);
        w++;
        if (w > 5 && devselNIn !== 1'b0) claimed = 1'b0;
      end while (trdyNIn !== 1'b0 && claimed && w < 64);
      if (claimed && rd) rdQ.push_back(adWire);
    end
    #1;
    frameN = 1'b1;
    irdyN = 1'b1;
    adDrvOe = 1'b0;
    cbeN = ~cbeN;
  endtask
endmodule

// ===== tb/tb_ptl_target.sv
// Self-checking bench for the target: writes, stalled burst, reads, misses.
// Assumes the initiator model in its own file; strobe wires pulled up.
module tb_ptl_target;
  timeunit 1ns;
  timeprecision 100ps;
  // Entry popped from the request port
  typedef struct packed {
    logic w;
    logic [2:0] bar;
    logic [7:0] off;
    logic [31:0] data;
    logic [3:0] be;
  } ptl_pop_s;

  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic frameN, irdyN, adDrvOe, trdyN, trdyOe, devselN, devselOe, adOe, busIdle;
  logic [3:0] cbeN;
  logic [31:0] adDrv, adOut, rspData, reqData;
  logic [31:0] adFloat = 32'h5a5a_5a5a;  // Released AD shows a changing pattern
  logic [63:0] barBase = {32'h0000_2000, 32'h0000_1000};
  logic [1:0] barEnable = 2'b11;
  logic reqValid, reqWrite, rspValid = 1'b0;
  logic reqReady = 1'b1;
  logic [2:0] reqBar;
  logic [7:0] reqOffset;
  logic [3:0] reqByteEn;
  logic [1:0] rspWait = 2'h0;
  logic driveSeen = 1'b0;
  ptl_pop_s popQ[$];
  int fails = 0;
  int n_compared = 0;

  // Wire resolution: pull-ups on strobes
  wire logic trdyWire = trdyOe ? trdyN : 1'b1;
  wire logic devselWire = devselOe ? devselN : 1'b1;
  wire logic [31:0] adWire = adDrvOe ? adDrv : (adOe ? adOut : adFloat);

  // Window 0 is I/O space, window 1 memory space
  ptl_target #(.NUM_BARS(2), .WIN_BITS(8), .BAR_IS_IO(6'h3d)) ptl_target_inst (
    .clock(clock), .rst_n(rst_n), .frameN(frameN), .irdyN(irdyN), .trdyNIn(trdyWire),
    .devselNIn(devselWire), .cbeN(cbeN), .adIn(adWire), .barBase(barBase),
    .barEnable(barEnable), .adOut(adOut), .adOe(adOe), .trdyN(trdyN), .trdyOe(trdyOe),
    .devselN(devselN), .devselOe(devselOe), .busIdle(busIdle), .reqValid(reqValid),
    .reqReady(reqReady), .reqWrite(reqWrite), .reqBar(reqBar), .reqOffset(reqOffset),
    .reqData(reqData), .reqByteEn(reqByteEn), .rspValid(rspValid), .rspData(rspData));

  ptl_initiator ptl_initiator_inst (
    .clock(clock), .trdyNIn(trdyWire), .devselNIn(devselWire), .adWire(adWire),
    .frameN(frameN), .irdyN(irdyN), .cbeN(cbeN), .adDrv(adDrv), .adDrvOe(adDrvOe));

  // 125 MHz clock
  initial begin
    forever #4 clock = ~clock;
  end

  // Pop log, read responder three cycles late, drive watcher
  always @(posedge clock) begin
    adFloat <= ~adFloat;
    rspValid <= (rspWait == 2'h1);
    rspWait <= (rspWait != 2'h0) ? rspWait - 2'h1 : 2'h0;
    if (devselOe || trdyOe || adOe) driveSeen <= 1'b1;
    if (reqValid === 1'b1 && reqReady === 1'b1) begin
      popQ.push_back({reqWrite, reqBar, reqOffset, reqData, reqByteEn});
      if (!reqWrite) begin
        rspWait <= 2'h3;
        rspData <= 32'hd000_0000 | reqOffset;
      end
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Release of the bus after the last transfer
  task automatic settle(input string name);
    repeat (3) @(posedge clock);
    #1;
    check("devselOe", 32'h0, {31'h0, devselOe});
    check("trdyOe", 32'h0, {31'h0, trdyOe});
    check("busIdle", 32'h1, {31'h0, busIdle});
    $display("test %s done", name);
  endtask

  // Single write into the second window
  task automatic t_write();
    logic ok;
    popQ.delete();
    ptl_initiator_inst.xfer(ptl_pkg::CMD_MEM_WR, 32'h0000_2010, 1, ok);
    check("claimed", 32'h1, {31'h0, ok});
    settle("write");
    check("bar", 32'h1, {29'h0, popQ[0].bar});
    check("offset", 32'h10, {24'h0, popQ[0].off});
    check("wr kind", 32'h1, {31'h0, popQ[0].w});
    check("data", 32'ha500_0000, popQ[0].data);
    check("be", 32'hf, {28'h0, popQ[0].be});
  endtask

  // Burst across the window end while the user stalls
  task automatic t_burst();
    logic ok;
    int i;
    popQ.delete();
    reqReady = 1'b0;
    fork
      ptl_initiator_inst.xfer(ptl_pkg::CMD_IO_WR, 32'h0000_10f8, 3, ok);
      begin
        repeat (10) @(posedge clock);
        #1;
        check("stall trdyN", 32'h1, {31'h0, trdyN});
        check("head valid", 32'h1, {31'h0, reqValid});
        reqReady = 1'b1;
      end
    join
    settle("burst");
    check("pops", 32'h3, popQ.size());
    for (i = 0; i < 3 && i < popQ.size(); i++) begin
      check("offset", {24'h0, 8'hf8 + 8'(4 * i)}, {24'h0, popQ[i].off});
      check("data", 32'ha500_0000 + i, popQ[i].data);
      check("be", {28'h0, ~4'(i)}, {28'h0, popQ[i].be});
    end
  endtask

  // Two-dword I/O read, then a one-dword memory read, served by the slow responder
  task automatic t_read();
    logic ok;
    popQ.delete();
    ptl_initiator_inst.rdQ.delete();
    ptl_initiator_inst.xfer(ptl_pkg::CMD_IO_RD, 32'h0000_1020, 2, ok);
    // Memory read starts on the cycle right after the release
    ptl_initiator_inst.xfer(ptl_pkg::CMD_MEM_RD_MUL, 32'h0000_2040, 1, ok);
    settle("read");
    check("rd claimed", 32'h1, {31'h0, ok});
    check("rd count", 32'h3, ptl_initiator_inst.rdQ.size());
    check("rd0", 32'hd000_0020, ptl_initiator_inst.rdQ[0]);
    check("rd1", 32'hd000_0024, ptl_initiator_inst.rdQ[1]);
    check("rd2", 32'hd000_0040, ptl_initiator_inst.rdQ[2]);
    check("rd kind", 32'h0, {31'h0, popQ[0].w});
    check("rd be", 32'hf, {28'h0, popQ[0].be});
  endtask

  // Disabled window and out-of-range address are left alone
  task automatic t_miss();
    logic ok;
    barEnable = 2'b01;
    driveSeen = 1'b0;
    popQ.delete();
    ptl_initiator_inst.xfer(ptl_pkg::CMD_MEM_WR, 32'h0000_2004, 1, ok);
    check("claimed off", 32'h0, {31'h0, ok});
    // Memory command into the I/O window is not ours
    ptl_initiator_inst.xfer(ptl_pkg::CMD_MEM_WR_INV, 32'h0000_1010, 1, ok);
    check("claimed space", 32'h0, {31'h0, ok});
    ptl_initiator_inst.xfer(ptl_pkg::CMD_IO_RD, 32'h0000_3000, 1, ok);
    settle("miss");
    check("claimed", 32'h0, {31'h0, ok});
    check("driven", 32'h0, {31'h0, driveSeen});
    check("pops", 32'h0, popQ.size());
    barEnable = 2'b11;
  endtask

  // Reset in mid-burst: the cut transaction is dropped, then the bus recovers
  task automatic t_reset();
    logic ok;
    fork
      ptl_initiator_inst.xfer(ptl_pkg::CMD_IO_WR, 32'h0000_1000, 3, ok);
      begin
        repeat (3) @(posedge clock);
        #1;
        rst_n = 1'b0;
        @(posedge clock);
        #1;
        rst_n = 1'b1;
        @(posedge clock);
        #1;
        check("rst2 devselOe", 32'h0, {31'h0, devselOe});
        check("rst2 reqValid", 32'h0, {31'h0, reqValid});
        @(posedge clock);
        #1;
        check("rst2 trdyOe", 32'h0, {31'h0, trdyOe});
      end
    join
    check("rst2 claimed", 32'h0, {31'h0, ok});
    settle("reset");
  endtask

  task automatic print_verdict();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence with watchdog
  initial begin
    fork
      begin
        repeat (4) @(posedge clock);
        check("rst devselOe", 32'h0, {31'h0, devselOe});
        check("rst busIdle", 32'h1, {31'h0, busIdle});
        #1;
        rst_n = 1'b1;
        t_write();
        t_burst();
        t_read();
        t_miss();
        t_reset();
        t_write();
      end
      begin
        #60000;
        fails++;
      end
    join_any
    print_verdict();
  end
endmodule
